// [common/ctw_params.svh]
// constants for the transceiver mode and pattern wake-up block
`ifndef CTW_PARAMS_SVH
`define CTW_PARAMS_SVH

// ****************************************
// clock and timebase
// ****************************************
`define CTW_CLK_MHZ 250
`define CTW_TICK_NS 100
`define CTW_TICK_CYC (`CTW_TICK_NS * `CTW_CLK_MHZ / 1000)

// ****************************************
// pattern wake-up timing
// ****************************************
`define CTW_PULSE_MIN_NS 500
`define CTW_PULSE_MAX_NS 500000
`define CTW_GAP_MAX_NS 500000
`define CTW_WINDOW_NS 1000000
`define CTW_PULSE_MIN_TK (`CTW_PULSE_MIN_NS / `CTW_TICK_NS)
`define CTW_PULSE_MAX_TK (`CTW_PULSE_MAX_NS / `CTW_TICK_NS)
`define CTW_GAP_MAX_TK (`CTW_GAP_MAX_NS / `CTW_TICK_NS)
`define CTW_WINDOW_TK (`CTW_WINDOW_NS / `CTW_TICK_NS)

// ****************************************
// slew-rate dependent path delays
// ****************************************
`define CTW_SLEW0_NS 8
`define CTW_SLEW1_NS 16
`define CTW_SLEW2_NS 24
`define CTW_SLEW3_NS 32
`define CTW_NS2CYC(ns) ((ns) * `CTW_CLK_MHZ / 1000)
`define CTW_DLY_DEPTH 8

// ****************************************
// register map
// ****************************************
`define CTW_REG_CTRL 4'h0
`define CTW_REG_STAT 4'h4
`define CTW_CTRL_SLEW_LSB 0
`define CTW_CTRL_MODE_LSB 2
`define CTW_CTRL_RST 4'h0
`define CTW_STAT_FLAG_BIT 0
`define CTW_STAT_CNT_LSB 1
`define CTW_STAT_ACT_BIT 3
`define CTW_STAT_CHIP_LSB 4

`endif

// [common/ctw_pkg.sv]
// types shared by the transceiver mode and wake-up block
`default_nettype none

package ctw_pkg;

	// system chip operating mode, driven by the chip state machine
	typedef enum logic [2:0] {
		CTW_CHIP_RESET,
		CTW_CHIP_NORM_REQ,
		CTW_CHIP_NORMAL,
		CTW_CHIP_STANDBY,
		CTW_CHIP_SLEEP,
		CTW_CHIP_STOP
	} ctw_chip_mode_t;

	// transceiver mode as written by software
	typedef enum logic [1:0] {
		CTW_CAN_ACTIVE_TRANSCEIVE_MODE,
		CTW_CAN_SLEEP_WU,
		CTW_CAN_SLEEP_NOWU,
		CTW_CAN_SLEEP_RSVD
	} ctw_can_mode_t;

endpackage : ctw_pkg

`default_nettype wire

// [core/ctw_sync.sv]
// two-stage synchroniser for asynchronous pin levels
`timescale 1ns/1ps
`default_nettype none

module ctw_sync #(
	parameter int W = 1
) (
	// clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// levels
	input wire logic [W-1:0] async,
	output logic [W-1:0] synced
);
	import ctw_pkg::*;

	logic [W-1:0] meta_r;

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			meta_r <= '0;
			synced <= '0;
		end else begin
			meta_r <= async;
			synced <= meta_r;
		end
	end

endmodule : ctw_sync

`default_nettype wire

// [core/ctw_wake_det.sv]
// pattern wake-up detector: width filter, pulse counter, timeouts
`timescale 1ns/1ps
`default_nettype none
`include "ctw_params.svh"

module ctw_wake_det #(
	parameter logic [13:0] MAX_TK = 14'(`CTW_PULSE_MAX_TK),
	parameter logic [13:0] GAP_TK = 14'(`CTW_GAP_MAX_TK),
	parameter logic [13:0] WIN_TK = 14'(`CTW_WINDOW_TK)
) (
	// clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// control and bus level
	input wire logic armed,
	input wire logic busDom,
	// results
	output logic wakePulse,
	output logic [1:0] pulseCnt
);
	import ctw_pkg::*;

	localparam logic [4:0] TICK_LAST = 5'(`CTW_TICK_CYC - 1);
	localparam logic [13:0] MIN_TK = 14'(`CTW_PULSE_MIN_TK);

	logic [4:0] tickDiv_r;
	logic tick;
	logic domPrev_r;
	logic [13:0] width_r;
	logic [13:0] gap_r;
	logic [13:0] win_r;
	logic rise;
	logic fall;
	logic accept;
	logic expired;
	logic [1:0] base;

	assign tick = (tickDiv_r == TICK_LAST);
	assign rise = busDom & ~domPrev_r;
	assign fall = domPrev_r & ~busDom;
	assign accept = fall && width_r > MIN_TK && width_r < MAX_TK;
	// only spacing and overall window count here, never frame content
	assign expired = (pulseCnt != 2'h0) &&
		(gap_r >= GAP_TK || win_r > WIN_TK);
	assign base = expired ? 2'h0 : pulseCnt;

	// ****************************************
	// 100 ns timebase
	// ****************************************
	always_ff @(posedge clk) begin
		if (sys_rst || !armed || tick) begin
			tickDiv_r <= 5'h0;
		end else begin
			tickDiv_r <= tickDiv_r + 5'h1;
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst || !armed) begin
			domPrev_r <= 1'b0;
		end else begin
			domPrev_r <= busDom;
		end
	end

	// ****************************************
	// width, gap and window counters
	// ****************************************
	always_ff @(posedge clk) begin
		if (sys_rst || !armed || rise) begin
			width_r <= 14'h0;
		end else if (busDom && tick && width_r != 14'h3FFF) begin
			width_r <= width_r + 14'h1;
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst || !armed || accept) begin
			gap_r <= 14'h0;
		end else if (tick && !busDom && gap_r != 14'h3FFF) begin
			gap_r <= gap_r + 14'h1;
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst || !armed || (rise && base == 2'h0)) begin
			win_r <= 14'h0;
		end else if (tick && win_r != 14'h3FFF) begin
			win_r <= win_r + 14'h1;
		end
	end

	// ****************************************
	// pulse counter and wake pulse
	// ****************************************
	always_ff @(posedge clk) begin
		if (sys_rst || !armed) begin
			pulseCnt <= 2'h0;
			wakePulse <= 1'b0;
		end else begin
			wakePulse <= accept && base == 2'h2;
			if (fall && !accept) begin
				pulseCnt <= 2'h0;
			end else if (accept) begin
				pulseCnt <= (base == 2'h2) ? 2'h0 : base + 2'h1;
			end else begin
				pulseCnt <= base;
			end
		end
	end

endmodule : ctw_wake_det

`default_nettype wire

// [core/ctw_mode_wakeup.sv]
// transceiver mode control, pin states, slew delays and wake-up flag
//
// Operation
// - four slew settings from the control register set both edge speeds.
// - slew setting also sets transmit, receive and loop path delays.
// - with ballast, non-normal modes hold transmit and receive pins low.
// - without ballast, receive high in normal-request, standby, normal sleep.
// - bus sleep with wake-up enabled detects traffic; disabled ignores it.
// - sleep command accepted whether secondary supply is on or off.
// - in bus sleep both drivers and receiver are off, lines float.
// - returning to active mode leaves both lines recessive.
// - wake-up enabled sleep uses the low-power receiver and a pattern.
// - valid pulse is wider than 500 ns, narrower than 500 us; three needed.
// - out-of-range pulse is discarded and clears the pulse counter.
// - gap of 500 us or more between pulses clears the pulse counter.
// - all three pulses must fall within one 1 ms window.
// - each accepted pulse counts; the third raises the wake signal.
// - wake-up ignores frame content; only the pulse pattern matters.
// - wake flag clears only when software commands active mode.
// - host transmit high asks recessive, low asks dominant.
// - receive pin high for recessive bus, low for dominant.
// - a bus wake-up sets a readable flag in the control register set.
`timescale 1ns/1ps
`default_nettype none
`include "ctw_params.svh"

module ctw_mode_wakeup #(
	parameter logic [13:0] MAX_TK = 14'(`CTW_PULSE_MAX_TK),
	parameter logic [13:0] GAP_TK = 14'(`CTW_GAP_MAX_TK),
	parameter logic [13:0] WIN_TK = 14'(`CTW_WINDOW_TK)
) (
	// clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// wishbone slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [3:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// chip context
	input wire ctw_pkg::ctw_chip_mode_t chipMode,
	input wire logic ballastFitted,
	input wire logic secSupplyOn,
	// host side pins
	input wire logic txdIn,
	output logic rxdOut,
	output logic txdHoldLow,
	// bus side analog controls
	input wire logic busDominant,
	input wire logic wakeRxDom,
	output logic canhDrvEn,
	output logic canlDrvEn,
	output logic busBiasEn,
	output logic rxEn,
	output logic wakeRxEn,
	output logic [1:0] slewSel,
	// wake-up towards chip state machine
	output logic wakeEvent
);
	import ctw_pkg::*;

	localparam int DD = `CTW_DLY_DEPTH;

	// ****************************************
	// helpers
	// ****************************************
	// tap index into the delay lines for a slew setting
	function automatic logic [2:0] dlyTap(input logic [1:0] s);
		logic [2:0] t;
		t = 3'h0;
		unique case (s)
			2'h0: t = 3'(`CTW_NS2CYC(`CTW_SLEW0_NS) - 1);
			2'h1: t = 3'(`CTW_NS2CYC(`CTW_SLEW1_NS) - 1);
			2'h2: t = 3'(`CTW_NS2CYC(`CTW_SLEW2_NS) - 1);
			2'h3: t = 3'(`CTW_NS2CYC(`CTW_SLEW3_NS) - 1);
		endcase
		return t;
	endfunction : dlyTap

	// transceiver mode field of a control word
	function automatic ctw_can_mode_t modeOf(input logic [3:0] v);
		return ctw_can_mode_t'(v[`CTW_CTRL_MODE_LSB +: 2]);
	endfunction : modeOf

	// ****************************************
	// pin synchronisers
	// ****************************************
	logic [4:0] pinSync;
	logic txdS;
	logic busDomS;
	logic wakeDomS;
	logic ballastS;
	logic supplyS;

	ctw_sync #(
		.W(5)
	) u_sync (
		.clk(clk),
		.sys_rst(sys_rst),
		.async({txdIn, busDominant, wakeRxDom, ballastFitted,
			secSupplyOn}),
		.synced(pinSync)
	);

	assign txdS = pinSync[4];
	assign busDomS = pinSync[3];
	assign wakeDomS = pinSync[2];
	assign ballastS = pinSync[1];
	assign supplyS = pinSync[0];

	// ****************************************
	// control register
	// ****************************************
	logic [3:0] ctrl_r;
	logic wakeFlag_r;
	logic [1:0] pulseCnt;
	logic wakePulse;
	logic busReq;
	logic wrCtrl;
	ctw_can_mode_t canMode;
	logic [1:0] slew;

	assign busReq = wb_cyc_i && wb_stb_i && !wb_ack_o;
	// the write lands on the edge where the master samples ack high
	assign wrCtrl = wb_cyc_i && wb_stb_i && wb_ack_o && wb_we_i &&
		wb_sel_i[0] && wb_adr_i == `CTW_REG_CTRL;
	assign slew = ctrl_r[`CTW_CTRL_SLEW_LSB +: 2];
	assign canMode = modeOf(ctrl_r);

	// written in any supply state, so sleep can be entered at 5 V
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			ctrl_r <= `CTW_CTRL_RST;
		end else if (wrCtrl) begin
			ctrl_r <= wb_dat_i[3:0];
		end
	end

	// ****************************************
	// wake-up flag
	// ****************************************
	logic toTxrx;

	assign toTxrx = wrCtrl && modeOf(wb_dat_i[3:0]) == CTW_CAN_ACTIVE_TRANSCEIVE_MODE;

	// a wake-up in the cycle of the clearing write still sets the flag
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			wakeFlag_r <= 1'b0;
		end else if (wakePulse) begin
			wakeFlag_r <= 1'b1;
		end else if (toTxrx) begin
			wakeFlag_r <= 1'b0;
		end
	end

	// ****************************************
	// bus slave answer
	// ****************************************
	logic [31:0] rdData;
	logic active;

	always_comb begin
		rdData = 32'h0000_0000;
		unique case (wb_adr_i)
			`CTW_REG_CTRL: rdData[3:0] = ctrl_r;
			`CTW_REG_STAT: begin
				rdData[`CTW_STAT_FLAG_BIT] = wakeFlag_r;
				rdData[`CTW_STAT_CNT_LSB +: 2] = pulseCnt;
				rdData[`CTW_STAT_ACT_BIT] = active;
				rdData[`CTW_STAT_CHIP_LSB +: 3] = chipMode;
			end
			default: rdData = 32'h0000_0000;
		endcase
	end

	// one wait state; unmapped addresses ack with zero data
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0000_0000;
		end else begin
			wb_ack_o <= busReq;
			wb_dat_o <= busReq ? rdData : 32'h0000_0000;
		end
	end

	// ****************************************
	// mode decode
	// ****************************************
	logic armed;
	logic rxdIdleHigh;

	// active only in chip normal with the transceiver supply up
	assign active = canMode == CTW_CAN_ACTIVE_TRANSCEIVE_MODE &&
		chipMode == CTW_CHIP_NORMAL && supplyS;
	assign armed = canMode == CTW_CAN_SLEEP_WU &&
		chipMode != CTW_CHIP_RESET;

	// idle receive level follows the secondary supply arrangement
	always_comb begin
		rxdIdleHigh = 1'b0;
		if (ballastS) begin
			rxdIdleHigh = chipMode == CTW_CHIP_NORMAL && supplyS;
		end else begin
			rxdIdleHigh = chipMode == CTW_CHIP_NORM_REQ ||
				chipMode == CTW_CHIP_STANDBY ||
				chipMode == CTW_CHIP_NORMAL;
		end
	end

	// ****************************************
	// slew-dependent delay lines
	// ****************************************
	logic [DD-1:0] txLine_r;
	logic [DD-1:0] rxLine_r;
	logic txDom;
	logic rxDom;

	// flushed to recessive outside active mode, so a stale dominant
	// never reaches the lines on return
	always_ff @(posedge clk) begin
		if (sys_rst || !active) begin
			txLine_r <= '0;
			rxLine_r <= '0;
		end else begin
			txLine_r <= {txLine_r[DD-2:0], ~txdS};
			rxLine_r <= {rxLine_r[DD-2:0], busDomS};
		end
	end

	assign txDom = txLine_r[dlyTap(slew)];
	assign rxDom = rxLine_r[dlyTap(slew)];

	// ****************************************
	// pin and driver outputs
	// ****************************************
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			canhDrvEn <= 1'b0;
			canlDrvEn <= 1'b0;
			busBiasEn <= 1'b0;
			rxEn <= 1'b0;
		end else begin
			canhDrvEn <= active && txDom;
			canlDrvEn <= active && txDom;
			busBiasEn <= active;
			rxEn <= active;
		end
	end

	// host pins fall back to the supply-dependent idle levels
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			rxdOut <= 1'b0;
			txdHoldLow <= 1'b1;
		end else begin
			rxdOut <= active ? !rxDom : rxdIdleHigh;
			txdHoldLow <= !active;
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			slewSel <= 2'h0;
		end else begin
			slewSel <= slew;
		end
	end

	// ****************************************
	// pattern wake-up
	// ****************************************
	ctw_wake_det #(
		.MAX_TK(MAX_TK),
		.GAP_TK(GAP_TK),
		.WIN_TK(WIN_TK)
	) u_wake (
		.clk(clk),
		.sys_rst(sys_rst),
		.armed(armed),
		.busDom(wakeDomS),
		.wakePulse(wakePulse),
		.pulseCnt(pulseCnt)
	);

	// low-power receiver only runs when wake-up is enabled
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			wakeRxEn <= 1'b0;
			wakeEvent <= 1'b0;
		end else begin
			wakeRxEn <= armed;
			wakeEvent <= wakePulse;
		end
	end

endmodule : ctw_mode_wakeup

`default_nettype wire

// [sim/ctw_mode_wakeup_assertions.sv]
// bound checker for the transceiver mode and wake-up block
`timescale 1ns/1ps
`default_nettype none

module ctw_mode_wakeup_chk #(
	parameter logic [13:0] MAX_TK = 14'h0028,
	parameter logic [13:0] GAP_TK = 14'h0028,
	parameter logic [13:0] WIN_TK = 14'h0050
) (
	// clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// register bus
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_ack_o,
	// chip context
	input wire ctw_pkg::ctw_chip_mode_t chipMode,
	input wire logic ballastFitted,
	// pins and bus controls
	input wire logic rxdOut,
	input wire logic txdHoldLow,
	input wire logic canhDrvEn,
	input wire logic canlDrvEn,
	input wire logic busBiasEn,
	input wire logic rxEn,
	input wire logic wakeRxEn,
	input wire logic wakeEvent
);
	import ctw_pkg::*;

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (sys_rst);

	// ****************************************
	// pin states
	// ****************************************
	// six cycles cover the two sync flops on the ballast pin
	sequence s_ballastIdle;
		(ballastFitted && chipMode != CTW_CHIP_NORMAL) [*6];
	endsequence
	sequence s_bareReq;
		(!ballastFitted && chipMode inside {CTW_CHIP_NORM_REQ,
			CTW_CHIP_STANDBY}) [*6];
	endsequence
	sequence s_bareOff;
		(!ballastFitted && chipMode inside {CTW_CHIP_RESET,
			CTW_CHIP_STOP}) [*6];
	endsequence
	property p_ballastLow;
		s_ballastIdle |-> !rxdOut && txdHoldLow;
	endproperty
	property p_bareReq;
		s_bareReq |-> rxdOut && txdHoldLow;
	endproperty
	property p_bareOff;
		s_bareOff |-> !rxdOut && txdHoldLow;
	endproperty
	property p_sleepOff;
		txdHoldLow [*4] |-> !canhDrvEn && !busBiasEn && !rxEn;
	endproperty
	property p_recEntry;
		$fell(txdHoldLow) |-> ##[0:2] (busBiasEn && !canhDrvEn);
	endproperty
	property p_drvPair;
		canhDrvEn == canlDrvEn;
	endproperty
	property p_rxExcl;
		!(rxEn && wakeRxEn);
	endproperty
	property p_wakeArmed;
		wakeEvent |-> $past(wakeRxEn);
	endproperty
	property p_wakeOnce;
		wakeEvent |=> !wakeEvent;
	endproperty
	property p_ackTimely;
		wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o;
	endproperty
	property p_ackPulse;
		wb_ack_o |=> !wb_ack_o;
	endproperty

	a_ballastLow: assert property (p_ballastLow)
		else $error("pins not low with ballast");
	a_bareReq: assert property (p_bareReq)
		else $error("receive pin not high without ballast");
	a_bareOff: assert property (p_bareOff)
		else $error("pins not low in reset or stop");
	a_sleepOff: assert property (p_sleepOff)
		else $error("line or receiver active when inactive");
	a_recEntry: assert property (p_recEntry)
		else $error("bus not recessive on entry");
	a_drvPair: assert property (p_drvPair)
		else $error("line drivers disagree");
	a_rxExcl: assert property (p_rxExcl)
		else $error("both receivers enabled");
	a_wakeArmed: assert property (p_wakeArmed)
		else $error("wake without wake receiver");
	a_wakeOnce: assert property (p_wakeOnce)
		else $error("wake pulse too long");
	a_ackTimely: assert property (p_ackTimely)
		else $error("register access not answered");
	a_ackPulse: assert property (p_ackPulse)
		else $error("ack held");
endmodule : ctw_mode_wakeup_chk

bind ctw_mode_wakeup ctw_mode_wakeup_chk #(
	.MAX_TK(MAX_TK), .GAP_TK(GAP_TK), .WIN_TK(WIN_TK)
) chk (
	.clk(clk), .sys_rst(sys_rst), .wb_cyc_i(wb_cyc_i),
	.wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .chipMode(chipMode),
	.ballastFitted(ballastFitted), .rxdOut(rxdOut),
	.txdHoldLow(txdHoldLow), .canhDrvEn(canhDrvEn),
	.canlDrvEn(canlDrvEn), .busBiasEn(busBiasEn), .rxEn(rxEn),
	.wakeRxEn(wakeRxEn), .wakeEvent(wakeEvent)
);

`default_nettype wire

// [sim/ctw_bus_model.sv]
// far-side bus model: remote node traffic and line comparators
`timescale 1ns/1ps
`default_nettype none

module ctw_bus_model #(
	parameter int TICK = 25
) (
	// clock
	input wire logic clk,
	// line drivers of the block
	input wire logic canhDrvEn,
	input wire logic canlDrvEn,
	// comparator outputs
	output logic busDominant,
	output logic wakeRxDom
);
	logic nodeDom;

	// undriven lines float to ground and read recessive
	assign busDominant = canhDrvEn & canlDrvEn;
	assign wakeRxDom = nodeDom | busDominant;

	initial nodeDom = 1'b0;

	// only widths and gaps matter, frame content is not modelled
	task automatic burst(input int w, input int g, input int n);
		for (int i = 0; i < n; i++) begin
			@(posedge clk);
			nodeDom <= 1'b1;
			repeat (w * TICK) @(posedge clk);
			nodeDom <= 1'b0;
			repeat (g * TICK - 1) @(posedge clk);
		end
	endtask : burst
endmodule : ctw_bus_model

`default_nettype wire

// [sim/ctw_mode_wakeup_bench.sv]
// self-checking bench for the transceiver mode and wake-up block
`timescale 1ns/1ps
`default_nettype none

module ctw_mode_wakeup_bench;
	import ctw_pkg::*;

	logic clk = 1'b0;
	logic sysRst = 1'b1;
	logic cyc = 1'b0, stb = 1'b0, we = 1'b0, ack;
	logic [3:0] adr = 4'h0, sel = 4'hF;
	logic [31:0] datW = 32'h0000_0000, datR, q;
	ctw_chip_mode_t chipMode = CTW_CHIP_NORMAL;
	logic ballast = 1'b1, secOn = 1'b1, txd = 1'b1, rxd, holdLow;
	logic busDom, wakeDom, drvH, drvL, bias, rxOn, wuEn, wakeEv;
	logic [1:0] slew;
	int errTotal = 0, nChecks = 0, wakes = 0, cycles = 0;
	int lat[4];

	always #2 clk = ~clk;

	ctw_mode_wakeup #(.MAX_TK(14'h0028), .GAP_TK(14'h0028),
		.WIN_TK(14'h0050)) uut (
		.clk(clk), .sys_rst(sysRst), .wb_cyc_i(cyc), .wb_stb_i(stb),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(datW),
		.wb_dat_o(datR), .wb_ack_o(ack), .chipMode(chipMode),
		.ballastFitted(ballast), .secSupplyOn(secOn), .txdIn(txd),
		.rxdOut(rxd), .txdHoldLow(holdLow), .busDominant(busDom),
		.wakeRxDom(wakeDom), .canhDrvEn(drvH), .canlDrvEn(drvL),
		.busBiasEn(bias), .rxEn(rxOn), .wakeRxEn(wuEn),
		.slewSel(slew), .wakeEvent(wakeEv));

	ctw_bus_model #(.TICK(25)) bus (.clk(clk), .canhDrvEn(drvH),
		.canlDrvEn(drvL), .busDominant(busDom), .wakeRxDom(wakeDom));

	// ****************************************
	// helpers
	// ****************************************
	task automatic summarize();
		$display("checks %0d mismatches %0d", nChecks, errTotal);
		if (errTotal == 0 && nChecks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : summarize

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		nChecks++;
		if (seen !== exp) begin
			errTotal++;
			$display("MISMATCH at %0t: saw %h, expected %h", $time, seen,
				exp);
		end
	endtask : check

	task automatic wb(input logic w, input logic [3:0] a,
		input logic [31:0] d);
		@(posedge clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		datW <= d;
		@(posedge clk);
		while (ack !== 1'b1) @(posedge clk);
		q = datR;
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask : wb

	// long idle lets the gap timeout clear the pulse counter
	task automatic expectWakes(input int n);
		repeat (1600) @(posedge clk);
		check(32'(wakes), 32'(n));
	endtask : expectWakes

	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (wakeEv === 1'b1)
			wakes <= wakes + 1;
		if (cycles == 60000) begin
			errTotal++;
			summarize();
		end
	end

	initial begin
		repeat (8) @(posedge clk);
		sysRst <= 1'b0;
		wb(0, 4'h0, 32'h0000_0000);
		check(q, 32'h0000_0000);
		wb(1, 4'h8, 32'hFFFF_FFFF);
		wb(0, 4'h8, 32'h0000_0000);
		check(q, 32'h0000_0000);
		wb(0, 4'h4, 32'h0000_0000);
		check(q, 32'h0000_0028);
		$display("registers done");
		for (int b = 0; b < 2; b++) begin
			for (int m = 0; m < 6; m++) begin
				@(posedge clk);
				ballast <= b[0];
				chipMode <= ctw_chip_mode_t'(m);
				repeat (10) @(posedge clk);
				if (m != 2) begin
					check(rxd, 32'(b == 0 && (m == 1 || m == 3)));
					check(holdLow, 32'h0000_0001);
				end
			end
		end
		$display("pin states done");
		chipMode <= CTW_CHIP_NORMAL;
		for (int s = 0; s < 4; s++) begin
			wb(1, 4'h0, 32'(s));
			repeat (10) @(posedge clk);
			check(slew, 32'(s));
			txd <= 1'b0;
			lat[s] = 0;
			while (drvH !== 1'b1) begin
				@(posedge clk);
				lat[s]++;
			end
			check(drvL, 32'h0000_0001);
			check(32'(lat[s] - lat[0]), 32'(2 * s));
			repeat (20) @(posedge clk);
			check(rxd, 32'h0000_0000);
			txd <= 1'b1;
			repeat (30) @(posedge clk);
			check({drvH, rxd}, 32'h0000_0001);
		end
		$display("slew paths done");
		wb(1, 4'h0, 32'h0000_0008);
		repeat (10) @(posedge clk);
		check({drvH, drvL, bias, rxOn, wuEn}, 32'h0000_0000);
		bus.burst(10, 10, 3);
		expectWakes(0);
		secOn <= 1'b0;
		wb(1, 4'h0, 32'h0000_0004);
		repeat (10) @(posedge clk);
		check({rxOn, wuEn}, 32'h0000_0001);
		bus.burst(10, 10, 2);
		wb(0, 4'h4, 32'h0000_0000);
		check(q[2:1], 32'h0000_0002);
		bus.burst(3, 10, 1);
		bus.burst(10, 10, 2);
		expectWakes(0);
		// short gaps keep the window open: only the width limit can fail
		bus.burst(10, 5, 2);
		bus.burst(45, 10, 1);
		expectWakes(0);
		// all three inside the window: only the gap limit can fail
		bus.burst(7, 42, 1);
		bus.burst(7, 5, 2);
		expectWakes(0);
		bus.burst(30, 30, 3);
		expectWakes(0);
		bus.burst(10, 10, 3);
		expectWakes(1);
		wb(0, 4'h4, 32'h0000_0000);
		check(q[0], 32'h0000_0001);
		$display("wake pattern done");
		wb(1, 4'h0, 32'h0000_0008);
		wb(0, 4'h4, 32'h0000_0000);
		check(q[0], 32'h0000_0001);
		secOn <= 1'b1;
		wb(1, 4'h0, 32'h0000_0000);
		wb(0, 4'h4, 32'h0000_0000);
		check(q[0], 32'h0000_0000);
		repeat (10) @(posedge clk);
		check({drvH, drvL, bias}, 32'h0000_0001);
		$display("return to active done");
		summarize();
	end
endmodule : ctw_mode_wakeup_bench

`default_nettype wire
